// ---- bit_logic_pkg.sv ----
// Shared constants and types for the bit logic word unit
// Contract
// [RULE1] AND, OR, XOR and invert each act on one 16-bit word.
// [RULE2] Other bit-string operations take strings of one to 256 words.
// [RULE3] String bits count from 1 at first word LSB up to last word MSB.
// [RULE4] Each enabled scan evaluates the operation bit by bit from the LSB.
// [RULE5] AND result bit is 1 only when both operand bits are 1.
// [RULE6] OR result bit is 0 only when both operand bits are 0.
// [RULE7] XOR result bit is 1 exactly when the operand bits differ.
// [RULE8] Invert writes the complement of the single operand every enabled scan.
// [RULE9] Ok is asserted in every scan where enable is asserted.
// [RULE10] XOR with second operand as result toggles bits under first operand ones.
// [RULE11] AND, OR, XOR operands are each an immediate or a memory word.
// [RULE12] Result may go to any writable area but not whole status area.
// [RULE13] AND gives a correct result even when its operand locations overlap.
// [RULE14] Programmer should avoid overlapping input and output ranges in multi-word work.
// [RULE15] Without enable the result location is untouched and ok is low.
package bit_logic_pkg;
   localparam int WORD_W           = 16;
   localparam int MAX_STRING_WORDS = 256;
   localparam int LEN_W            = 9;
   localparam int BIT_NUM_W        = 13;
   localparam int WORD_SEL_W       = 8;
   localparam int BIT_POS_W        = 4;
   localparam logic [BIT_NUM_W-1:0] FIRST_BIT_NUM = 13'h0001;
   localparam logic [LEN_W-1:0]     MIN_LEN       = 9'h001;
   localparam logic [LEN_W-1:0]     MAX_LEN       = 9'h100;
   localparam logic [WORD_W-1:0]    WORD_ZERO     = 16'h0000;

   typedef enum logic [1:0] {
      op_and,
      op_or,
      op_xor,
      op_not
   } logic_op_t;

   typedef enum logic [2:0] {
      area_general,
      area_status_subarea_one,
      area_status_subarea_two,
      area_status_subarea_three,
      area_status_whole
   } dest_area_t;
endpackage

// ---- word_mem_if.sv ----
// Interface between the unit control and its word memory
`timescale 1ns/1ps
interface word_mem_if #(
   parameter int ADDR_W = 10,
   parameter int DATA_W = 16
);
   logic [ADDR_W-1:0] raddr;
   logic [DATA_W-1:0] rdata;
   logic              wen;
   logic [ADDR_W-1:0] waddr;
   logic [DATA_W-1:0] wdata;

   modport ctrl  (output raddr, output wen, output waddr, output wdata, input rdata);
   modport store (input raddr, input wen, input waddr, input wdata, output rdata);
endinterface

// ---- word_store.sv ----
// Controller data memory with registered read port
`timescale 1ns/1ps
module word_store #(
   parameter int ADDR_W = 10,
   parameter int DATA_W = 16
) (
   input  wire logic   ref_clk,
   word_mem_if.store   mem
);
   logic [DATA_W-1:0] words [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] rdata_r;

   always_ff @(posedge ref_clk) begin
      if (mem.wen) begin
         words[mem.waddr] <= mem.wdata;
      end
      rdata_r <= words[mem.raddr];
   end

   assign mem.rdata = rdata_r;
endmodule // word_store

// ---- bit_logic_word_unit.sv ----
// Word-wide logic operation unit with data memory and bit locator
`timescale 1ns/1ps
module bit_logic_word_unit #(
   parameter int ADDR_W = 10
) (
   input  wire logic                                 ref_clk,
   input  wire logic                                 rst,
   input  wire logic                                 scan_strobe,
   input  wire logic                                 enable,
   input  wire bit_logic_pkg::logic_op_t             op_sel,
   input  wire logic                                 first_operand_is_const,
   input  wire logic [bit_logic_pkg::WORD_W-1:0]     first_operand_const,
   input  wire logic [ADDR_W-1:0]                    first_operand_addr,
   input  wire logic                                 second_operand_is_const,
   input  wire logic [bit_logic_pkg::WORD_W-1:0]     second_operand_const,
   input  wire logic [ADDR_W-1:0]                    second_operand_addr,
   input  wire logic [ADDR_W-1:0]                    result_addr,
   input  wire bit_logic_pkg::dest_area_t            result_area,
   input  wire logic                                 host_wr_en,
   input  wire logic [ADDR_W-1:0]                    host_addr,
   input  wire logic [bit_logic_pkg::WORD_W-1:0]     host_wdata,
   output logic      [bit_logic_pkg::WORD_W-1:0]     host_rdata,
   input  wire logic [bit_logic_pkg::LEN_W-1:0]      locate_len,
   input  wire logic [bit_logic_pkg::BIT_NUM_W-1:0]  locate_bit,
   output logic      [bit_logic_pkg::WORD_SEL_W-1:0] locate_word,
   output logic      [bit_logic_pkg::BIT_POS_W-1:0]  locate_pos,
   output logic                                      locate_valid,
   output logic                                      busy,
   output logic                                      scan_done,
   output logic                                      ok,
   output logic                                      dest_refused,
   output logic      [bit_logic_pkg::WORD_W-1:0]     result_word
);
   // ****************************************************************
   // Types, state and memory
   // ****************************************************************
   typedef enum logic [1:0] {
      st_idle,
      st_read_first,
      st_read_second,
      st_exec
   } scan_state_t;

   scan_state_t                            state_r;
   scan_state_t                            state_nxt;
   bit_logic_pkg::logic_op_t               op_r;
   bit_logic_pkg::dest_area_t              area_r;
   logic                                   first_const_sel_r;
   logic                                   second_const_sel_r;
   logic [bit_logic_pkg::WORD_W-1:0]       first_const_r;
   logic [bit_logic_pkg::WORD_W-1:0]       second_const_r;
   logic [ADDR_W-1:0]                      first_addr_r;
   logic [ADDR_W-1:0]                      second_addr_r;
   logic [ADDR_W-1:0]                      result_addr_r;
   logic [bit_logic_pkg::WORD_W-1:0]       first_word_r;
   logic [bit_logic_pkg::WORD_W-1:0]       result_word_r;
   logic                                   scan_done_r;
   logic                                   ok_r;
   logic                                   dest_refused_r;
   logic [bit_logic_pkg::WORD_SEL_W-1:0]   locate_word_r;
   logic [bit_logic_pkg::BIT_POS_W-1:0]    locate_pos_r;
   logic                                   locate_valid_r;

   word_mem_if #(.ADDR_W(ADDR_W), .DATA_W(bit_logic_pkg::WORD_W)) mem ();

   word_store #(.ADDR_W(ADDR_W), .DATA_W(bit_logic_pkg::WORD_W)) u_store (
      .ref_clk (ref_clk),
      .mem     (mem.store)
   );

   // ****************************************************************
   // Operand selection and bitwise evaluation
   // ****************************************************************
   wire logic                             idle        = (state_r == st_idle);
   wire logic                             start_scan  = idle & scan_strobe;
   wire logic [bit_logic_pkg::WORD_W-1:0] first_word  = first_const_sel_r ? first_const_r
                                                                          : first_word_r; // RULE11
   wire logic [bit_logic_pkg::WORD_W-1:0] second_word = second_const_sel_r ? second_const_r
                                                                           : mem.rdata; // RULE11
   wire logic                             area_ok     =
      (area_r != bit_logic_pkg::area_status_whole); // RULE12
   logic [bit_logic_pkg::WORD_W-1:0]      eval_word;

   function automatic logic eval_bit(input bit_logic_pkg::logic_op_t op,
                                     input logic a, input logic b);
      case (op)
         bit_logic_pkg::op_and: eval_bit = a & b; // RULE5
         bit_logic_pkg::op_or:  eval_bit = a | b; // RULE6
         bit_logic_pkg::op_xor: eval_bit = a ^ b; // RULE7
         default:               eval_bit = ~a; // RULE8
      endcase
   endfunction

   // One cell per bit, LSB first, on a single word
   genvar gi;
   generate
      for (gi = 0; gi < bit_logic_pkg::WORD_W; gi++) begin : g_bit // RULE1 RULE4
         assign eval_word[gi] = eval_bit(op_r, first_word[gi], second_word[gi]);
      end
   endgenerate

   // ****************************************************************
   // Memory port steering
   // ****************************************************************
   // Both operands are read before the write, so overlap is harmless
   assign mem.raddr = (state_r == st_read_first)  ? first_addr_r :
                      (state_r == st_read_second) ? second_addr_r :
                      host_addr; // RULE13
   assign mem.wen   = ((state_r == st_exec) & area_ok) |
                      (idle & host_wr_en & ~scan_strobe); // RULE12 RULE10
   assign mem.waddr = (state_r == st_exec) ? result_addr_r : host_addr;
   assign mem.wdata = (state_r == st_exec) ? eval_word : host_wdata;

   // ****************************************************************
   // Scan sequencer
   // ****************************************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         st_idle:        if (scan_strobe && enable) begin
                            state_nxt = st_read_first; // RULE4
                         end
         st_read_first:  state_nxt = st_read_second;
         st_read_second: state_nxt = st_exec;
         st_exec:        state_nxt = st_idle;
         default:        state_nxt = st_idle;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_r <= st_idle;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         op_r               <= bit_logic_pkg::op_and;
         area_r             <= bit_logic_pkg::area_general;
         first_const_sel_r  <= 1'b0;
         second_const_sel_r <= 1'b0;
         first_const_r      <= bit_logic_pkg::WORD_ZERO;
         second_const_r     <= bit_logic_pkg::WORD_ZERO;
         first_addr_r       <= '0;
         second_addr_r      <= '0;
         result_addr_r      <= '0;
      end else if (start_scan) begin
         op_r               <= op_sel;
         area_r             <= result_area;
         first_const_sel_r  <= first_operand_is_const;
         second_const_sel_r <= second_operand_is_const;
         first_const_r      <= first_operand_const;
         second_const_r     <= second_operand_const;
         first_addr_r       <= first_operand_addr;
         second_addr_r      <= second_operand_addr;
         result_addr_r      <= result_addr;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         first_word_r <= bit_logic_pkg::WORD_ZERO;
      end else if (state_r == st_read_second) begin
         first_word_r <= mem.rdata;
      end
   end

   // ****************************************************************
   // Scan completion flags and result
   // ****************************************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         scan_done_r    <= 1'b0;
         ok_r           <= 1'b0;
         dest_refused_r <= 1'b0;
         result_word_r  <= bit_logic_pkg::WORD_ZERO;
      end else begin
         scan_done_r    <= (start_scan & ~enable) | (state_r == st_exec);
         ok_r           <= (state_r == st_exec); // RULE9 RULE15
         dest_refused_r <= (state_r == st_exec) & ~area_ok; // RULE12
         if (state_r == st_exec) begin
            result_word_r <= eval_word; // RULE8
         end
      end
   end

   // ****************************************************************
   // String bit locator
   // ****************************************************************
   wire logic [bit_logic_pkg::BIT_NUM_W-1:0] bit_index = locate_bit - bit_logic_pkg::FIRST_BIT_NUM;
   wire logic [bit_logic_pkg::WORD_SEL_W-1:0] word_index =
      bit_index[bit_logic_pkg::BIT_POS_W +: bit_logic_pkg::WORD_SEL_W];
   wire logic [bit_logic_pkg::BIT_NUM_W-1:0] bit_limit =
      {locate_len[bit_logic_pkg::LEN_W-1:0], {bit_logic_pkg::BIT_POS_W{1'b0}}};
   wire logic len_ok = (locate_len >= bit_logic_pkg::MIN_LEN) &
                       (locate_len <= bit_logic_pkg::MAX_LEN); // RULE2
   wire logic bit_ok = (locate_bit >= bit_logic_pkg::FIRST_BIT_NUM) &
                       (locate_bit <= bit_limit); // RULE3

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         locate_word_r  <= '0;
         locate_pos_r   <= '0;
         locate_valid_r <= 1'b0;
      end else begin
         locate_word_r  <= word_index; // RULE3
         locate_pos_r   <= bit_index[bit_logic_pkg::BIT_POS_W-1:0]; // RULE3
         locate_valid_r <= len_ok & bit_ok;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign host_rdata   = mem.rdata;
   assign busy         = ~idle;
   assign scan_done    = scan_done_r;
   assign ok           = ok_r;
   assign dest_refused = dest_refused_r;
   assign result_word  = result_word_r;
   assign locate_word  = locate_word_r;
   assign locate_pos   = locate_pos_r;
   assign locate_valid = locate_valid_r;
endmodule // bit_logic_word_unit

// ---- bit_logic_word_unit_assertions.sv ----
// Port-level assertions for the bit logic word unit
`timescale 1ns/1ps
module bit_logic_word_unit_assertions (
   input wire logic                             ref_clk,
   input wire logic                             rst,
   input wire logic                             scan_strobe,
   input wire logic                             enable,
   input wire logic                             busy,
   input wire logic                             scan_done,
   input wire logic                             ok,
   input wire logic                             dest_refused,
   input wire logic [15:0]                      result_word,
   input wire bit_logic_pkg::dest_area_t        result_area,
   input wire logic [8:0]                       locate_len,
   input wire logic [12:0]                      locate_bit,
   input wire logic [7:0]                       locate_word,
   input wire logic [3:0]                       locate_pos,
   input wire logic                             locate_valid
);
   // ****************************
   // Helper decode of the locator
   // ****************************
   wire logic        loc_ok;
   wire logic [11:0] loc_idx;
   wire logic        take;
   assign loc_ok  = locate_len != 9'h000 && locate_len <= 9'h100 && locate_bit != 13'h0000
                    && locate_bit <= {locate_len, 4'h0};
   assign loc_idx = 12'(locate_bit - 13'h0001);
   assign take    = scan_strobe && !busy;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_ok_done; ok |-> scan_done; endproperty
   a_ok_done: assert property (p_ok_done) else $error("ok seen without scan_done");
   property p_en_ok; take && enable |-> ##[1:4] (scan_done && ok); endproperty
   a_en_ok: assert property (p_en_ok) else $error("enabled scan gave no ok");
   property p_dis; take && !enable |=> scan_done && !ok; endproperty
   a_dis: assert property (p_dis) else $error("disabled scan misreported");
   property p_hold; $changed(result_word) |-> scan_done && ok; endproperty
   a_hold: assert property (p_hold) else $error("result changed outside a scan");
   property p_ref_ok; dest_refused |-> ok; endproperty
   a_ref_ok: assert property (p_ref_ok) else $error("refusal without ok");
   property p_ref; take && enable && result_area == bit_logic_pkg::area_status_whole
      |-> ##[1:4] dest_refused; endproperty
   a_ref: assert property (p_ref) else $error("whole status area not refused");
   property p_loc_valid; 1'b1 |=> locate_valid == $past(loc_ok); endproperty
   a_loc_valid: assert property (p_loc_valid) else $error("locator valid wrong");
   property p_loc_idx; loc_ok |=> {locate_word, locate_pos} == $past(loc_idx); endproperty
   a_loc_idx: assert property (p_loc_idx) else $error("locator position wrong");
endmodule // bit_logic_word_unit_assertions

// ---- tb_bit_logic_word_unit.sv ----
// Self-checking bench for the bit logic word unit
`timescale 1ns/1ps
module tb_bit_logic_word_unit;
   logic ref_clk = 1'b0, rst = 1'b1, scan_strobe = 1'b0, enable = 1'b0, host_wr_en = 1'b0;
   logic first_operand_is_const = 1'b1, second_operand_is_const = 1'b1;
   logic [15:0] first_operand_const = 16'h0000, second_operand_const = 16'h0000;
   logic [15:0] host_wdata = 16'h0000, host_rdata, result_word;
   logic [9:0] first_operand_addr = 10'h000, second_operand_addr = 10'h000;
   logic [9:0] result_addr = 10'h000, host_addr = 10'h000;
   logic [8:0] locate_len = 9'h001;
   logic [12:0] locate_bit = 13'h0001;
   logic [7:0] locate_word;
   logic [3:0] locate_pos;
   logic locate_valid, busy, scan_done, ok, dest_refused;
   bit_logic_pkg::logic_op_t op_sel = bit_logic_pkg::op_and;
   bit_logic_pkg::dest_area_t result_area = bit_logic_pkg::area_general;
   int fails = 0, num_checks = 0, cycles = 0;

   bit_logic_word_unit #(.ADDR_W(10)) dut (.ref_clk, .rst, .scan_strobe, .enable, .op_sel,
      .first_operand_is_const, .first_operand_const, .first_operand_addr,
      .second_operand_is_const, .second_operand_const, .second_operand_addr, .result_addr,
      .result_area, .host_wr_en, .host_addr, .host_wdata, .host_rdata, .locate_len,
      .locate_bit, .locate_word, .locate_pos, .locate_valid, .busy, .scan_done, .ok,
      .dest_refused, .result_word);

   always #5 ref_clk = ~ref_clk;

   // **************
   // Shared helpers
   // **************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         $display("MISMATCH timeout expected finish seen hang");
         print_verdict();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic hw(input logic [9:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      #1;
      host_wr_en = 1'b1;
      host_addr = a;
      host_wdata = d;
      @(posedge ref_clk);
      #1;
      host_wr_en = 1'b0;
   endtask

   task automatic rd(input logic [9:0] a, input logic [15:0] exp);
      @(posedge ref_clk);
      #1;
      host_addr = a;
      @(posedge ref_clk);
      #1;
      chk("memory word", exp, host_rdata);
   endtask

   // Operands double as addresses when not immediate
   task automatic scan(input logic en, input bit_logic_pkg::logic_op_t op, input logic fc,
         input logic [15:0] a, input logic sc, input logic [15:0] b, input logic [9:0] ra,
         input bit_logic_pkg::dest_area_t ar);
      int n;
      @(posedge ref_clk);
      #1;
      scan_strobe = 1'b1;
      enable = en;
      op_sel = op;
      first_operand_is_const = fc;
      first_operand_const = a;
      first_operand_addr = a[9:0];
      second_operand_is_const = sc;
      second_operand_const = b;
      second_operand_addr = b[9:0];
      result_addr = ra;
      result_area = ar;
      @(posedge ref_clk);
      #1;
      scan_strobe = 1'b0;
      chk("busy", {15'h0, en}, {15'h0, busy});
      n = 0;
      while (scan_done !== 1'b1 && n < 8) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk("done ok refused", {13'h0, 1'b1, en, en && ar == bit_logic_pkg::area_status_whole},
          {13'h0, scan_done, ok, dest_refused});
   endtask

   // *********
   // Scenarios
   // *********
   task automatic t_ops();
      logic [15:0] ex[4] = '{16'h03a0, 16'hcff5, 16'hcc55, 16'h3c5a};
      for (int i = 0; i < 4; i++) begin
         scan(1'b1, bit_logic_pkg::logic_op_t'(i), 1'b1, 16'hc3a5, 1'b1, 16'h0ff0, 10'(16 + i),
              bit_logic_pkg::area_general);
         chk("result_word", ex[i], result_word);
         rd(10'(16 + i), ex[i]);
      end
   endtask

   task automatic t_mem();
      hw(10'h001, 16'h5a5a);
      hw(10'h002, 16'h0ff0);
      scan(1'b1, bit_logic_pkg::op_and, 1'b0, 16'h0001, 1'b0, 16'h0002, 10'h003,
           bit_logic_pkg::area_general);
      rd(10'h003, 16'h0a50);
      scan(1'b1, bit_logic_pkg::op_or, 1'b1, 16'hff00, 1'b0, 16'h0001, 10'h004,
           bit_logic_pkg::area_general);
      rd(10'h004, 16'hff5a);
      scan(1'b1, bit_logic_pkg::op_and, 1'b0, 16'h0001, 1'b0, 16'h0001, 10'h001,
           bit_logic_pkg::area_general);
      rd(10'h001, 16'h5a5a);
   endtask

   task automatic t_toggle();
      logic [15:0] w = 16'h0f0f;
      hw(10'h005, w);
      repeat (3) begin
         scan(1'b1, bit_logic_pkg::op_xor, 1'b1, 16'h00ff, 1'b0, 16'h0005, 10'h005,
              bit_logic_pkg::area_general);
         w = w ^ 16'h00ff;
         rd(10'h005, w);
      end
   endtask

   task automatic t_off();
      logic [15:0] held = result_word;
      scan(1'b0, bit_logic_pkg::op_not, 1'b1, 16'h1234, 1'b1, 16'h0000, 10'h005,
           bit_logic_pkg::area_general);
      chk("held result_word", held, result_word);
      rd(10'h005, 16'h0ff0);
   endtask

   task automatic t_area();
      for (int i = 1; i < 5; i++) begin
         hw(10'h008, 16'h0000);
         scan(1'b1, bit_logic_pkg::op_not, 1'b1, 16'h00f0, 1'b1, 16'h0000, 10'h008,
              bit_logic_pkg::dest_area_t'(i));
         rd(10'h008, (i == 4) ? 16'h0000 : 16'hff0f);
      end
   endtask

   task automatic t_locate();
      logic [8:0] ln[7] = '{9'h003, 9'h001, 9'h100, 9'h003, 9'h001, 9'h000, 9'h101};
      logic [12:0] bt[7] = '{13'h0030, 13'h0001, 13'h1000, 13'h0031, 13'h0000, 13'h0001,
                             13'h0001};
      logic [15:0] ex[7] = '{16'h102f, 16'h1000, 16'h1fff, 16'h0, 16'h0, 16'h0, 16'h0};
      logic [15:0] got;
      for (int i = 0; i < 7; i++) begin
         @(posedge ref_clk);
         #1;
         locate_len = ln[i];
         locate_bit = bt[i];
         @(posedge ref_clk);
         #1;
         got = {3'h0, locate_valid, locate_word, locate_pos};
         chk("locator", ex[i], ex[i][12] ? got : (got & 16'h1000));
      end
   endtask

   task automatic t_reset();
      @(posedge ref_clk);
      #1;
      rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      chk("reset flags", 16'h0000,
          {11'h0, busy, scan_done, ok, dest_refused, locate_valid});
      chk("reset result_word", 16'h0000, result_word);
      scan(1'b1, bit_logic_pkg::op_or, 1'b1, 16'h0001, 1'b1, 16'h0002, 10'h009,
           bit_logic_pkg::area_status_subarea_two);
      rd(10'h009, 16'h0003);
   endtask

   initial begin
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      t_ops();
      t_mem();
      t_toggle();
      t_off();
      t_area();
      t_locate();
      t_reset();
      print_verdict();
   end
endmodule // tb_bit_logic_word_unit

bind bit_logic_word_unit bit_logic_word_unit_assertions u_chk (.ref_clk, .rst, .scan_strobe,
   .enable, .busy, .scan_done, .ok, .dest_refused, .result_word, .result_area, .locate_len,
   .locate_bit, .locate_word, .locate_pos, .locate_valid);
